/* pkg/anms_map.vh */
`ifndef ANMS_MAP_VH
`define ANMS_MAP_VH

// Register word indices; byte address is four times the index
`define ANMS_IDX_BMC        8'h00
`define ANMS_IDX_ADV        8'h04
`define ANMS_IDX_PARTNER    8'h05
`define ANMS_IDX_PAMS       8'h19
`define ANMS_ADDR_W         8

// Basic mode control fields
`define ANMS_BMC_SWRST      15
`define ANMS_BMC_SPEED      13
`define ANMS_BMC_AN_EN      12
`define ANMS_BMC_RESTART    9
`define ANMS_BMC_DUPLEX     8
`define ANMS_BMC_RST        16'h3100
`define ANMS_BMC_WMASK      16'h7fff

// Ability field [8:5]: 10 half, 10 full, 100 half, 100 full
`define ANMS_ABIL_LSB       5
`define ANMS_ABIL_MSB       8
`define ANMS_ADV_SELECTOR   5'h01
`define ANMS_ABIL_ALL       4'hf

// Address/mode status fields
`define ANMS_PAMS_AN_EN     10
`define ANMS_PAMS_DUPLEX    7
`define ANMS_PAMS_SPEED10   6

// Strap states
`define ANMS_STRAP_LOW      2'h0
`define ANMS_STRAP_MID      2'h1
`define ANMS_STRAP_HIGH     2'h2
`define ANMS_STRAP_CLK      2'h3

// Strap clock detection timing
`define ANMS_SYS_CLK_MHZ    100
`define ANMS_STRAP_CLK_MHZ  25
`define ANMS_STRAP_PERIODS  4
`define ANMS_STRAP_WIN_CYC  (`ANMS_STRAP_PERIODS * \
                             (`ANMS_SYS_CLK_MHZ / `ANMS_STRAP_CLK_MHZ))
`define ANMS_STRAP_MIN_EDGES 2

`endif

/* rtl/anms_strap_decode.v */
`timescale 1ns/1ps
`include "anms_map.vh"

module anms_strap_decode (
  // Clock and reset
  input  wire       i_mclk,
  input  wire       i_rstn,
  // Sampling window
  input  wire       i_sample,
  // Comparator outputs: full-rail and half-rail thresholds
  input  wire       i_cmp_full,
  input  wire       i_cmp_half,
  // Decoded state
  output reg  [1:0] o_state
);

  reg       half_prev_q;
  reg       primed_q;
  reg [2:0] edges_q;
  wire      edge_seen;
  wire[2:0] edges_d;
  reg [1:0] level;

  // First sample only seeds the history, so no false edge after reset
  assign edge_seen = primed_q && (i_cmp_half ^ half_prev_q);
  assign edges_d   = (edge_seen && edges_q != 3'h7) ? edges_q + 3'h1
                                                    : edges_q;

  always @* begin
    if (i_cmp_full)
      level = `ANMS_STRAP_HIGH;
    else if (i_cmp_half)
      level = `ANMS_STRAP_MID;
    else
      level = `ANMS_STRAP_LOW;
  end

  always @(posedge i_mclk) begin
    if (!i_rstn) begin
      half_prev_q <= 1'b0;
      primed_q    <= 1'b0;
      edges_q     <= 3'h0;
      o_state     <= `ANMS_STRAP_LOW;
    end else if (i_sample) begin
      half_prev_q <= i_cmp_half;
      primed_q    <= 1'b1;
      edges_q     <= edges_d;
      if (edges_d >= `ANMS_STRAP_MIN_EDGES)
        o_state <= `ANMS_STRAP_CLK;
      else
        o_state <= level;
    end
  end

endmodule // anms_strap_decode

/* rtl/anms_prio_resolve.v */
`timescale 1ns/1ps

module anms_prio_resolve (
  // Local and partner abilities, [0]=10H [1]=10F [2]=100H [3]=100F
  input  wire [3:0] i_local,
  input  wire [3:0] i_partner,
  // Resolved technology
  output reg        o_found,
  output reg        o_speed_100,
  output reg        o_full_duplex
);

  wire [3:0] common;

  assign common = i_local & i_partner;

  always @* begin
    o_found       = 1'b1;
    o_speed_100   = 1'b0;
    o_full_duplex = 1'b0;
    if (common[3]) begin
      o_speed_100   = 1'b1;
      o_full_duplex = 1'b1;
    end else if (common[2]) begin
      o_speed_100   = 1'b1;
    end else if (common[1]) begin
      o_full_duplex = 1'b1;
    end else if (!common[0]) begin
      o_found       = 1'b0;
    end
  end

endmodule // anms_prio_resolve

/* rtl/anms_mode_select.v */
`timescale 1ns/1ps
`include "anms_map.vh"

// Overview of operation
// - Each strap pin decodes to low, mid, high or 25 MHz clock.
// - Hardware reset straps set status bits 6, 7, 10 and ability bits 8:5.
// - Software reset enables negotiation and advertises all four abilities.
// - Strap negotiation choice leaves mode control untouched; shows in bit 10.
// - Writing mode control at any time replaces strap negotiation, speed and duplex; strap abilities stay unless soft reset.
// - With negotiation on, advertisement register abilities go to the partner.
// - Status bits 10, 7, 6 show actual negotiation, duplex and speed.
// - Duplex and speed bits valid only when negotiation off or complete.
// - Resolve common ability: 100 full, 100 half, 10 full, 10 half.
// - Negotiation off: control bit 13 picks speed, bit 8 picks duplex.
// - Negotiation on: speed and duplex control bits have no effect.
// - Straps low/mid and high/mid force 10 Mb/s half and full duplex.
// - Straps mid/low and mid/high force 100 Mb/s half and full duplex.
// - Clock strap mixes with mid force 100 Mb/s with listed advertisements.
// - Both straps mid enable negotiation advertising all four abilities.
// - Plain level straps enable negotiation advertising one ability.
// - Clock and level strap mixes enable negotiation with listed abilities.
// - Mid means half supply; high and low are logic levels.
// - Writing one to control bit 9 with bit 12 also one restarts negotiation.
module anms_mode_select #(
  parameter WIN_CYC = `ANMS_STRAP_WIN_CYC
) (
  // Clock and reset
  input  wire        i_mclk,
  input  wire        i_rstn,
  // APB slave
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [9:0]  i_paddr,
  input  wire [31:0] i_pwdata,
  output wire        o_pready,
  output wire        o_pslverr,
  output reg  [31:0] o_prdata,
  // Strap comparators, high pin then low pin
  input  wire        i_strap_hi_full,
  input  wire        i_strap_hi_half,
  input  wire        i_strap_lo_full,
  input  wire        i_strap_lo_half,
  // Negotiation engine
  input  wire [15:0] i_partner_ability,
  input  wire        i_an_complete,
  output reg         o_an_enable,
  output reg  [3:0]  o_adv_abilities,
  output reg         o_an_restart,
  // Operating mode
  output reg         o_mode_valid,
  output reg         o_speed_100,
  output reg         o_full_duplex
);

  localparam ST_SAMPLE = 2'h0;
  localparam ST_LOAD   = 2'h1;
  localparam ST_RUN    = 2'h2;

  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg  [15:0] win_cnt_q;
  reg  [15:0] bmc_q;
  reg  [3:0]  adv_q;
  reg         an_en_q;
  reg         fspd_q;
  reg         fdup_q;
  reg         ready_q;

  wire [1:0]  cfg_strap_hi;
  wire [1:0]  cfg_strap_lo;
  wire        sampling;
  wire        win_done;
  wire        loading;
  wire        run;

  reg         st_an_en;
  reg  [3:0]  st_adv;
  reg         st_spd100;
  reg         st_full;

  wire        res_found;
  wire        res_spd100;
  wire        res_full;
  reg         cur_valid;
  reg         cur_spd100;
  reg         cur_full;

  wire        setup;
  wire        wr_en;
  wire        access;
  wire        aligned;
  wire [7:0]  idx;
  reg         mapped;
  reg  [15:0] rd_word;
  wire [15:0] wdat;

  assign sampling = (state_q == ST_SAMPLE);
  assign win_done = (win_cnt_q == WIN_CYC[15:0] - 16'h1);
  assign loading  = (state_q == ST_LOAD);
  assign run      = (state_q == ST_RUN);

  // One decoder per strap pin, both sampling the same window
  anms_strap_decode u_dec_hi (
    .i_mclk     (i_mclk),
    .i_rstn     (i_rstn),
    .i_sample   (sampling),
    .i_cmp_full (i_strap_hi_full),
    .i_cmp_half (i_strap_hi_half),
    .o_state    (cfg_strap_hi)
  );

  anms_strap_decode u_dec_lo (
    .i_mclk     (i_mclk),
    .i_rstn     (i_rstn),
    .i_sample   (sampling),
    .i_cmp_full (i_strap_lo_full),
    .i_cmp_half (i_strap_lo_half),
    .o_state    (cfg_strap_lo)
  );

  // Strap table
  // Forced rows turn negotiation off, advertised rows leave it on
  always @* begin
    st_an_en  = 1'b1;
    st_adv    = `ANMS_ABIL_ALL;
    st_spd100 = 1'b1;
    st_full   = 1'b1;
    case ({cfg_strap_hi, cfg_strap_lo})
      {`ANMS_STRAP_LOW, `ANMS_STRAP_MID}: begin
        st_an_en  = 1'b0;
        st_adv    = 4'h1;
        st_spd100 = 1'b0;
        st_full   = 1'b0;
      end
      {`ANMS_STRAP_HIGH, `ANMS_STRAP_MID}: begin
        st_an_en  = 1'b0;
        st_adv    = 4'h2;
        st_spd100 = 1'b0;
      end
      {`ANMS_STRAP_MID, `ANMS_STRAP_LOW}: begin
        st_an_en  = 1'b0;
        st_adv    = 4'h4;
        st_full   = 1'b0;
      end
      {`ANMS_STRAP_MID, `ANMS_STRAP_HIGH}: begin
        st_an_en  = 1'b0;
        st_adv    = 4'h8;
      end
      {`ANMS_STRAP_CLK, `ANMS_STRAP_MID}: begin
        st_an_en  = 1'b0;
        st_adv    = 4'hc;
      end
      {`ANMS_STRAP_MID, `ANMS_STRAP_CLK}: begin
        st_an_en  = 1'b0;
        st_adv    = 4'ha;
      end
      {`ANMS_STRAP_CLK, `ANMS_STRAP_CLK}: begin
        st_an_en  = 1'b0;
        st_adv    = 4'h5;
        st_full   = 1'b0;
      end
      {`ANMS_STRAP_MID, `ANMS_STRAP_MID}: begin
        st_adv    = `ANMS_ABIL_ALL;
      end
      {`ANMS_STRAP_LOW, `ANMS_STRAP_LOW}: begin
        st_adv    = 4'h1;
      end
      {`ANMS_STRAP_LOW, `ANMS_STRAP_HIGH}: begin
        st_adv    = 4'h2;
      end
      {`ANMS_STRAP_HIGH, `ANMS_STRAP_LOW}: begin
        st_adv    = 4'h4;
      end
      {`ANMS_STRAP_HIGH, `ANMS_STRAP_HIGH}: begin
        st_adv    = 4'h8;
      end
      {`ANMS_STRAP_CLK, `ANMS_STRAP_HIGH}: begin
        st_adv    = 4'ha;
      end
      {`ANMS_STRAP_CLK, `ANMS_STRAP_LOW}: begin
        st_adv    = 4'h5;
      end
      {`ANMS_STRAP_HIGH, `ANMS_STRAP_CLK}: begin
        st_adv    = 4'hc;
      end
      {`ANMS_STRAP_LOW, `ANMS_STRAP_CLK}: begin
        st_adv    = 4'h3;
      end
      default: begin
        st_adv    = `ANMS_ABIL_ALL;
      end
    endcase
  end

  // Strap window then normal operation
  always @* begin
    case (state_q)
      ST_SAMPLE: state_d = win_done ? ST_LOAD : ST_SAMPLE;
      ST_LOAD:   state_d = ST_RUN;
      ST_RUN:    state_d = ST_RUN;
      default:   state_d = ST_SAMPLE;
    endcase
  end

  always @(posedge i_mclk) begin
    if (!i_rstn) begin
      state_q   <= ST_SAMPLE;
      win_cnt_q <= 16'h0;
    end else begin
      state_q   <= state_d;
      if (sampling)
        win_cnt_q <= win_cnt_q + 16'h1;
    end
  end

  // Ready lags RUN by a cycle: a read parked during the window
  // recaptures its word after the strap defaults have landed
  always @(posedge i_mclk) begin
    if (!i_rstn)
      ready_q <= 1'b0;
    else
      ready_q <= run;
  end

  // APB decode; no answer until straps are latched
  assign idx       = i_paddr[9:2];
  assign setup     = i_psel && !i_penable;
  assign access    = i_psel && i_penable && o_pready;
  assign aligned   = (i_paddr[1:0] == 2'h0);
  assign o_pready  = ready_q;
  // Unmapped or misaligned words answer with an error, writes dropped
  assign o_pslverr = access && (!mapped || !aligned);
  assign wr_en     = access && i_pwrite && mapped && aligned;
  assign wdat      = i_pwdata[15:0];

  always @* begin
    mapped  = 1'b1;
    rd_word = 16'h0;
    case (idx)
      `ANMS_IDX_BMC:     rd_word = bmc_q;
      `ANMS_IDX_ADV:     rd_word = {7'h0, adv_q, `ANMS_ADV_SELECTOR};
      `ANMS_IDX_PARTNER: rd_word = i_partner_ability;
      // Duplex and speed read zero until the mode is settled
      `ANMS_IDX_PAMS: begin
        rd_word[`ANMS_PAMS_AN_EN]   = an_en_q;
        rd_word[`ANMS_PAMS_DUPLEX]  = cur_valid && cur_full;
        rd_word[`ANMS_PAMS_SPEED10] = cur_valid && !cur_spd100;
      end
      default:           mapped  = 1'b0;
    endcase
  end

  // Read word keeps refreshing until the access is answered
  always @(posedge i_mclk) begin
    if (!i_rstn)
      o_prdata <= 32'h0;
    else if (setup || (i_psel && !o_pready))
      o_prdata <= {16'h0, rd_word};
  end

  // Control registers
  always @(posedge i_mclk) begin
    if (!i_rstn) begin
      bmc_q        <= `ANMS_BMC_RST;
      adv_q        <= `ANMS_ABIL_ALL;
      an_en_q      <= 1'b1;
      fspd_q       <= 1'b1;
      fdup_q       <= 1'b1;
      o_an_restart <= 1'b0;
    end else begin
      o_an_restart <= 1'b0;
      if (loading) begin
        adv_q   <= st_adv;
        an_en_q <= st_an_en;
        fspd_q  <= st_spd100;
        fdup_q  <= st_full;
      end else if (wr_en && idx == `ANMS_IDX_BMC) begin
        // Soft reset restores defaults and clears itself
        if (wdat[`ANMS_BMC_SWRST]) begin
          bmc_q   <= `ANMS_BMC_RST;
          adv_q   <= `ANMS_ABIL_ALL;
          an_en_q <= 1'b1;
          fspd_q  <= 1'b1;
          fdup_q  <= 1'b1;
        end else begin
          bmc_q   <= wdat & `ANMS_BMC_WMASK & ~16'h0200;
          an_en_q <= wdat[`ANMS_BMC_AN_EN];
          fspd_q  <= wdat[`ANMS_BMC_SPEED];
          fdup_q  <= wdat[`ANMS_BMC_DUPLEX];
          // Restart bit is never stored; it only pulses the engine
          o_an_restart <= wdat[`ANMS_BMC_RESTART] &&
                          wdat[`ANMS_BMC_AN_EN];
        end
      end else if (wr_en && idx == `ANMS_IDX_ADV) begin
        // Only the ability field is writable; selector is fixed
        adv_q <= wdat[`ANMS_ABIL_MSB:`ANMS_ABIL_LSB];
      end
    end
  end

  anms_prio_resolve u_prio (
    .i_local       (adv_q),
    .i_partner     (i_partner_ability[`ANMS_ABIL_MSB:`ANMS_ABIL_LSB]),
    .o_found       (res_found),
    .o_speed_100   (res_spd100),
    .o_full_duplex (res_full)
  );

  // Operating mode selection
  // Negotiated mode counts only once the engine reports completion
  always @* begin
    if (an_en_q) begin
      cur_valid  = i_an_complete && res_found;
      cur_spd100 = res_spd100;
      cur_full   = res_full;
    end else begin
      cur_valid  = 1'b1;
      cur_spd100 = fspd_q;
      cur_full   = fdup_q;
    end
  end

  always @(posedge i_mclk) begin
    if (!i_rstn) begin
      o_an_enable     <= 1'b0;
      o_adv_abilities <= 4'h0;
      o_mode_valid    <= 1'b0;
      o_speed_100     <= 1'b0;
      o_full_duplex   <= 1'b0;
    end else begin
      o_an_enable     <= an_en_q && run;
      o_adv_abilities <= adv_q;
      o_mode_valid    <= cur_valid && run;
      o_speed_100     <= cur_spd100;
      o_full_duplex   <= cur_full;
    end
  end

endmodule // anms_mode_select

/* test/anms_link_partner.sv */
`timescale 1ns/1ps

module anms_link_partner (
  // Clock and reset
  input  wire        i_mclk,
  input  wire        i_rstn,
  // Local device
  input  wire        i_an_enable,
  input  wire        i_an_restart,
  // Behaviour
  input  wire [3:0]  i_abil,
  input  wire [7:0]  i_delay,
  // Toward the device
  output wire [15:0] o_partner_ability,
  output reg         o_an_complete
);
  reg  [7:0]  cnt_q;
  wire [15:0] word;
  assign word = {7'h00, i_abil, 5'h01};
  // Word is garbage until the exchange completes
  assign o_partner_ability = o_an_complete ? word : ~word;
  always @(posedge i_mclk) begin
    if (!i_rstn || !i_an_enable || i_an_restart) begin
      cnt_q         <= 8'h00;
      o_an_complete <= 1'b0;
    end else if (cnt_q == i_delay) begin
      o_an_complete <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule // anms_link_partner

/* test/anms_mode_select_sva.sv */
`timescale 1ns/1ps

module anms_mode_select_sva (
  // Clock and reset
  input wire        i_mclk,
  input wire        i_rstn,
  // APB
  input wire        i_psel,
  input wire        i_penable,
  input wire        i_pwrite,
  input wire [9:0]  i_paddr,
  input wire [31:0] i_pwdata,
  input wire        o_pready,
  input wire        o_pslverr,
  input wire [31:0] o_prdata,
  // Straps
  input wire        i_strap_hi_full,
  input wire        i_strap_hi_half,
  input wire        i_strap_lo_full,
  input wire        i_strap_lo_half,
  // Negotiation and mode
  input wire [15:0] i_partner_ability,
  input wire        i_an_complete,
  input wire        o_an_enable,
  input wire [3:0]  o_adv_abilities,
  input wire        o_an_restart,
  input wire        o_mode_valid,
  input wire        o_speed_100,
  input wire        o_full_duplex
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  wire       wr  = i_psel && i_penable && o_pready && i_pwrite;
  wire       won = o_an_enable && i_an_complete;
  wire [3:0] com = o_adv_abilities & i_partner_ability[8:5];
  wire       wctl = wr && i_paddr == 10'h000 && !i_pwdata[15];

  a_ready_hold: assert property (o_pready |=> o_pready)
    else $error("ready dropped");
  a_run_valid: assert property ((o_pready && !o_an_enable) [*2]
    |-> o_mode_valid) else $error("forced mode not valid");
  a_wait_done: assert property ((o_an_enable && !i_an_complete) [*2]
    |-> !o_mode_valid) else $error("mode valid before completion");
  a_prio_top: assert property (won && com[3]
    ##1 (o_an_enable && $stable(o_adv_abilities))
    |-> o_mode_valid && o_speed_100 && o_full_duplex)
    else $error("top priority not chosen");
  a_prio_low: assert property (won && com == 4'h1
    ##1 (o_an_enable && $stable(o_adv_abilities))
    |-> o_mode_valid && !o_speed_100 && !o_full_duplex)
    else $error("lowest priority wrong");
  a_restart_write: assert property (wctl && i_pwdata[9] && i_pwdata[12]
    |=> o_an_restart) else $error("restart missing");
  a_restart_cause: assert property (o_an_restart
    |-> $past(wctl && i_pwdata[9]) ##1 !o_an_restart)
    else $error("restart pulse bad");
  a_adv_write: assert property (wr && i_paddr == 10'h010
    |=> ##1 o_adv_abilities == $past(i_pwdata[8:5], 2))
    else $error("advertisement not updated");
  a_ctl_forced: assert property (wctl && !i_pwdata[12]
    |=> ##1 (!o_an_enable && o_speed_100 == $past(i_pwdata[13], 2)
    && o_full_duplex == $past(i_pwdata[8], 2)))
    else $error("forced speed or duplex wrong");

  c_restart: cover property (o_an_restart);
  c_prio_mid: cover property (won && com == 4'h7);
  c_forced: cover property ($rose(o_mode_valid) && !o_an_enable);
endmodule // anms_mode_select_sva

bind anms_mode_select anms_mode_select_sva u_sva (
  .i_mclk, .i_rstn, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
  .o_pready, .o_pslverr, .o_prdata, .i_strap_hi_full, .i_strap_hi_half,
  .i_strap_lo_full, .i_strap_lo_half, .i_partner_ability, .i_an_complete,
  .o_an_enable, .o_adv_abilities, .o_an_restart, .o_mode_valid,
  .o_speed_100, .o_full_duplex
);

/* test/anms_mode_select_test.sv */
`timescale 1ns/1ps
`include "anms_map.vh"

module anms_mode_select_test;
  localparam [1:0] L = `ANMS_STRAP_LOW, M = `ANMS_STRAP_MID;
  localparam [1:0] H = `ANMS_STRAP_HIGH, C = `ANMS_STRAP_CLK;
  localparam [9:0] A_CTL = {`ANMS_IDX_BMC, 2'b00};
  localparam [9:0] A_ADV = {`ANMS_IDX_ADV, 2'b00};
  localparam [9:0] A_ST  = {`ANMS_IDX_PAMS, 2'b00};
  reg        i_mclk = 0, i_rstn = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
  reg [9:0]  i_paddr = 0;
  reg [31:0] i_pwdata = 0;
  reg [1:0]  st_hi = M, st_lo = M;
  reg        sck = 0, sdiv = 0;
  reg [3:0]  p_abil = 4'hf;
  reg [7:0]  p_dly = 8'd200;
  wire       o_pready, o_pslverr, i_an_complete, o_an_enable, o_an_restart;
  wire       o_mode_valid, o_speed_100, o_full_duplex;
  wire       i_strap_hi_full, i_strap_hi_half, i_strap_lo_full, i_strap_lo_half;
  wire [31:0] o_prdata;
  wire [15:0] i_partner_ability;
  wire [3:0]  o_adv_abilities;
  reg  [31:0] rdv;
  logic       err;
  int         n_errors = 0, checks = 0;

  always #5 i_mclk = ~i_mclk;
  // 25 MHz strap clock
  always @(posedge i_mclk) begin
    sdiv <= ~sdiv;
    if (sdiv) sck <= ~sck;
  end
  function [1:0] cmp(input [1:0] s, input k);
    cmp = (s == C) ? {k, k} : {s == H, s != L};
  endfunction
  assign {i_strap_hi_full, i_strap_hi_half} = cmp(st_hi, sck);
  assign {i_strap_lo_full, i_strap_lo_half} = cmp(st_lo, sck);

  anms_mode_select #(.WIN_CYC(8)) dut (
    .i_mclk, .i_rstn, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_pready, .o_pslverr, .o_prdata, .i_strap_hi_full, .i_strap_hi_half,
    .i_strap_lo_full, .i_strap_lo_half, .i_partner_ability, .i_an_complete,
    .o_an_enable, .o_adv_abilities, .o_an_restart, .o_mode_valid,
    .o_speed_100, .o_full_duplex);
  anms_link_partner lp (.i_mclk, .i_rstn, .i_an_enable(o_an_enable),
    .i_an_restart(o_an_restart), .i_abil(p_abil), .i_delay(p_dly),
    .o_partner_ability(i_partner_ability), .o_an_complete(i_an_complete));

  task conclude;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task apb(input w, input [9:0] a, input [15:0] d);
    int n;
    @(posedge i_mclk);
    i_psel <= 1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= {16'h0000, d};
    @(posedge i_mclk);
    i_penable <= 1;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_pready !== 1'b1 && n < 500);
    if (n >= 500) n_errors++;
    rdv = o_prdata;
    err = o_pslverr;
    i_psel <= 0;
    i_penable <= 0;
  endtask
  task rd(input [9:0] a, input [31:0] e, input string nm);
    apb(0, a, 16'h0000);
    chk(nm, e, rdv);
  endtask
  task hreset(input [1:0] h, input [1:0] l);
    @(posedge i_mclk);
    st_hi <= h;
    st_lo <= l;
    i_rstn <= 0;
    repeat (6) @(posedge i_mclk);
    i_rstn <= 1;
  endtask
  task sc(input [1:0] h, input [1:0] l, input [15:0] adv, input [15:0] st);
    hreset(h, l);
    rd(A_ST, st, "status");
    rd(A_ADV, adv, "adv");
    rd(A_CTL, 16'h3100, "control");
  endtask
  task mode(input [15:0] st, input s, input f);
    rd(A_ST, st, "status");
    chk("speed", s, o_speed_100);
    chk("duplex", f, o_full_duplex);
  endtask
  task neg(input [3:0] pa, input [15:0] st, input s, input f);
    int n;
    p_abil <= pa;
    apb(1, A_CTL, 16'h1200);
    repeat (3) @(posedge i_mclk);
    n = 0;
    while (o_mode_valid !== 1'b1 && n < 100) begin
      @(posedge i_mclk);
      n++;
    end
    mode(st, s, f);
  endtask

  initial begin
    sc(L, M, 16'h021, 16'h040);
    sc(M, L, 16'h081, 16'h000);
    sc(M, H, 16'h101, 16'h080);
    sc(C, M, 16'h181, 16'h080);
    sc(M, C, 16'h141, 16'h080);
    sc(C, C, 16'h0a1, 16'h000);
    sc(L, L, 16'h021, 16'h400);
    sc(L, H, 16'h041, 16'h400);
    sc(H, L, 16'h081, 16'h400);
    sc(H, H, 16'h101, 16'h400);
    sc(C, H, 16'h141, 16'h400);
    sc(C, L, 16'h0a1, 16'h400);
    sc(H, C, 16'h181, 16'h400);
    sc(L, C, 16'h061, 16'h400);
    sc(M, M, 16'h1e1, 16'h400);
    st_hi <= L;
    st_lo <= L;
    repeat (4) @(posedge i_mclk);
    rd(A_ADV, 16'h1e1, "adv");
    p_dly <= 8'd1;
    neg(4'hf, 16'h480, 1, 1);
    rd(10'h014, 16'h1e1, "partner");
    neg(4'h7, 16'h400, 1, 0);
    neg(4'h3, 16'h4c0, 0, 1);
    neg(4'h1, 16'h440, 0, 0);
    p_dly <= 8'd40;
    apb(1, A_ADV, 16'h0061);
    rd(A_ADV, 16'h061, "adv");
    chk("adv_out", 4'h3, o_adv_abilities);
    neg(4'hf, 16'h4c0, 0, 1);
    for (int k = 0; k < 4; k++) begin
      apb(1, A_CTL, {2'b00, k[1], 4'h0, k[0], 8'h00});
      repeat (2) @(posedge i_mclk);
      mode({8'h00, k[0], ~k[1], 6'h00}, k[1], k[0]);
    end
    apb(1, A_ST, 16'hffff);
    rd(A_ST, 16'h080, "status");
    apb(0, 10'h008, 16'h0000);
    chk("slverr", 1, err);
    apb(1, A_ADV | 10'h001, 16'h01e0);
    chk("slverr_misaligned", 1, err);
    rd(A_ADV, 16'h061, "adv");
    p_dly <= 8'd200;
    apb(1, A_CTL, 16'h8000);
    rd(A_CTL, 16'h3100, "control");
    rd(A_ADV, 16'h1e1, "adv");
    rd(A_ST, 16'h400, "status");
    sc(H, M, 16'h041, 16'h0c0);
    p_dly <= 8'd1;
    apb(1, A_CTL, 16'h0000);
    neg(4'hf, 16'h4c0, 0, 1);
    conclude;
  end
  initial begin
    repeat (5000) @(posedge i_mclk);
    n_errors++;
    conclude;
  end
endmodule // anms_mode_select_test
